// file: core/ubis_pkg.sv
package ubis_pkg;

  // Register indices; byte address is four times the index
  localparam logic [3:0] UBIS_IDX_BUF    = 4'h0;
  localparam logic [3:0] UBIS_IDX_IRQEN  = 4'h1;
  localparam logic [3:0] UBIS_IDX_IRQST  = 4'h2;
  localparam logic [3:0] UBIS_IDX_LCR    = 4'h3;
  localparam logic [3:0] UBIS_IDX_MCR    = 4'h4;
  localparam logic [3:0] UBIS_IDX_LSR    = 4'h5;
  localparam logic [3:0] UBIS_IDX_MSR    = 4'h6;
  localparam logic [3:0] UBIS_IDX_SCR    = 4'h7;
  localparam logic [3:0] UBIS_IDX_CFG    = 4'h8;
  // Divisor bytes live in set 1 at indices 0 and 1
  localparam logic [3:0] UBIS_IDX_DIVLO  = 4'h0;
  localparam logic [3:0] UBIS_IDX_DIVHI  = 4'h1;

  // Field positions
  localparam int UBIS_LCR_SET1_BIT   = 7;  // Legacy divisor access
  localparam int UBIS_SSR_WRITE_BIT  = 7;  // Advanced: write is a set select
  localparam int UBIS_MCR_IRQ_OE_BIT = 3;
  localparam int UBIS_BCR_FIFO_EN    = 0;
  localparam int UBIS_BCR_RXRST      = 1;
  localparam int UBIS_BCR_TXRST      = 2;
  localparam int UBIS_CFG_FAST       = 0;
  localparam int UBIS_CFG_TURBO      = 1;
  localparam int UBIS_CFG_BANK       = 3;

  // Reset values
  localparam logic [7:0]  UBIS_RST_BYTE = 8'h00;
  localparam logic [15:0] UBIS_RST_DIV  = 16'h000c;
  localparam logic [2:0]  UBIS_RST_SET  = 3'h0;

  // Encoded interrupt identifiers, bit 0 low while pending
  localparam logic [3:0] UBIS_ID_NONE  = 4'h1;
  localparam logic [3:0] UBIS_ID_LINE  = 4'h6;
  localparam logic [3:0] UBIS_ID_RX    = 4'h4;
  localparam logic [3:0] UBIS_ID_TX    = 4'h2;
  localparam logic [3:0] UBIS_ID_MODEM = 4'h0;

  // Timing: 24 MHz source made from core_clk by a fractional accumulator
  localparam int UBIS_CORE_KHZ  = 125000;
  localparam int UBIS_SRC_KHZ   = 24000;
  localparam int UBIS_FAST_KHZ  = 14746;  // 16 x 921600
  localparam int UBIS_PRESCALE  = 13;     // 24 MHz / 13 = 1.8461 MHz

  localparam logic [1:0] UBIS_RESP_OKAY   = 2'b00;
  localparam logic [1:0] UBIS_RESP_SLVERR = 2'b10;

  // Interrupt sources from the rest of the port
  typedef struct packed {
    logic modem_change;
    logic line_error;
    logic tx_empty;
    logic rx_ready;
  } ubis_irq_src_t;

  // Configuration bits
  typedef struct packed {
    logic bank_switch_enable;
    logic turbo_rate_select;
    logic fast_rate_select;
  } ubis_cfg_t;

  typedef enum logic [1:0] {
    UBIS_RD_IDLE = 2'b00,
    UBIS_RD_RESP = 2'b01
  } ubis_rd_state_t;

endpackage

// file: core/ubis_uart_regs.sv
// Register access over AXI4-Lite is this design's own decision.
module ubis_uart_regs
  import ubis_pkg::*;
#(
  parameter int ADDR_W = 6
) (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Port datapath and status, same clock
  input  wire ubis_irq_src_t       irq_src,
  input  wire logic [7:0]          rx_data,
  input  wire logic [7:0]          line_status_in,
  input  wire logic [7:0]          modem_status_in,
  // Strobes toward the port
  output logic                     rx_read_q,
  output logic                     tx_write_q,
  output logic [7:0]               tx_data_q,
  output logic                     line_status_rd_q,
  output logic                     modem_status_rd_q,
  output logic                     irq_ident_rd_q,
  output logic                     rx_fifo_clr_q,
  output logic                     tx_fifo_clr_q,
  // Control toward the port
  output logic [7:0]               line_ctrl_q,
  output logic [7:0]               modem_ctrl_q,
  output logic [7:0]               buffer_ctrl_q,
  output logic                     advanced_mode_q,
  output logic [2:0]               set_select_q,
  output logic                     baud16_q,
  output logic                     irq_q
);

  localparam logic [16:0] ACC_MOD  = 17'(UBIS_CORE_KHZ);
  localparam logic [16:0] ACC_SRC  = 17'(UBIS_SRC_KHZ);
  localparam logic [16:0] ACC_FAST = 17'(UBIS_FAST_KHZ);
  localparam logic [3:0]  PRE_TOP  = 4'(UBIS_PRESCALE - 1);

  // Register state
  logic [3:0]   irq_en_q;
  logic [7:0]   scratch_q;
  logic [15:0]  divisor_q;
  ubis_cfg_t    cfg_q;
  logic [2:0]   set_q;

  // Write channel holding
  logic              aw_held_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic              w_held_q;
  logic [31:0]       w_data_q;
  logic              w_strb0_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;

  // Read channel
  ubis_rd_state_t    rd_state_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;

  // Map a byte address to a register index; misaligned or high bits give an illegal index
  function automatic logic [4:0] reg_index(input logic [ADDR_W-1:0] addr);
    logic [4:0] idx;
    idx = 5'h1f;
    if (addr[1:0] == 2'b00 && addr[ADDR_W-1:2] <= (ADDR_W-2)'(UBIS_IDX_CFG)) begin
      idx = {1'b0, 4'(addr[ADDR_W-1:2])};
    end
    return idx;
  endfunction

  // Effective set: legacy mode uses the line control divisor bit to reach set 1
  function automatic logic [2:0] active_set(input logic adv, input logic [2:0] sel, input logic [7:0] lcr);
    logic [2:0] s;
    s = 3'h0;
    if (adv) begin
      s = sel;
    end else if (lcr[UBIS_LCR_SET1_BIT]) begin
      s = 3'h1;
    end
    return s;
  endfunction

  // Highest-priority pending enabled source, encoded
  function automatic logic [3:0] encode_irq(input logic [3:0] pend);
    logic [3:0] id;
    id = UBIS_ID_NONE;
    if (pend[2]) begin
      id = UBIS_ID_LINE;
    end else if (pend[0]) begin
      id = UBIS_ID_RX;
    end else if (pend[1]) begin
      id = UBIS_ID_TX;
    end else if (pend[3]) begin
      id = UBIS_ID_MODEM;
    end
    return id;
  endfunction

  logic        wr_fire;
  logic [4:0]  wr_idx;
  logic [2:0]  cur_set;
  logic [3:0]  pending;
  logic        wr_set0;
  logic        wr_set1;
  logic        wr_map;

  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign wr_idx  = reg_index(aw_addr_q);
  assign cur_set = active_set(cfg_q.bank_switch_enable, set_q, line_ctrl_q);
  // Each source is masked by its own enable bit
  assign pending = {irq_src.modem_change, irq_src.line_error,
                    irq_src.tx_empty, irq_src.rx_ready} & irq_en_q;
  // Byte lane 0 carries every register; other lanes are ignored
  assign wr_map  = wr_fire && w_strb0_q && !wr_idx[4];
  assign wr_set0 = wr_map && cur_set == 3'h0;
  assign wr_set1 = wr_map && cur_set == 3'h1;

  // Address and data are taken in either order and held until the write fires
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
      w_held_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb0_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q  <= 1'b1;
        w_data_q  <= s_axi_wdata;
        w_strb0_q <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready  = !w_held_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // Write response; an unmapped index answers SLVERR
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= UBIS_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_idx[4] ? UBIS_RESP_SLVERR : UBIS_RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Interrupt enables; only the low four bits exist
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_en_q <= 4'h0;
    end else if (wr_set0 && wr_idx[3:0] == UBIS_IDX_IRQEN) begin
      irq_en_q <= w_data_q[3:0];
    end
  end

  // Scratch byte, no side effects
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scratch_q <= UBIS_RST_BYTE;
    end else if (wr_set0 && wr_idx[3:0] == UBIS_IDX_SCR) begin
      scratch_q <= w_data_q[7:0];
    end
  end

  // Modem control and buffer control; buffer clear bits fall back by themselves
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      modem_ctrl_q  <= UBIS_RST_BYTE;
      buffer_ctrl_q <= UBIS_RST_BYTE;
    end else begin
      if (wr_set0 && wr_idx[3:0] == UBIS_IDX_MCR) begin
        modem_ctrl_q <= w_data_q[7:0];
      end
      if (wr_set0 && wr_idx[3:0] == UBIS_IDX_IRQST) begin
        buffer_ctrl_q <= w_data_q[7:0];
      end else begin
        buffer_ctrl_q[UBIS_BCR_RXRST] <= 1'b0;
        buffer_ctrl_q[UBIS_BCR_TXRST] <= 1'b0;
      end
    end
  end

  // Offset 3 is decoded in every set so the active set can always be changed
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      line_ctrl_q <= UBIS_RST_BYTE;
      set_q       <= UBIS_RST_SET;
    end else if (wr_map && wr_idx[3:0] == UBIS_IDX_LCR) begin
      if (cfg_q.bank_switch_enable && w_data_q[UBIS_SSR_WRITE_BIT]) begin
        set_q <= w_data_q[2:0];
      end else begin
        line_ctrl_q <= w_data_q[7:0];
        set_q       <= UBIS_RST_SET;
      end
    end
  end

  // Configuration bits sit outside the set scheme at index 8
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_q <= '0;
    end else if (wr_map && wr_idx[3:0] == UBIS_IDX_CFG) begin
      cfg_q.fast_rate_select   <= w_data_q[UBIS_CFG_FAST];
      cfg_q.turbo_rate_select  <= w_data_q[UBIS_CFG_TURBO];
      cfg_q.bank_switch_enable <= w_data_q[UBIS_CFG_BANK];
    end
  end

  // Divisor bytes are reached through set 1
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      divisor_q <= UBIS_RST_DIV;
    end else if (wr_set1) begin
      if (wr_idx[3:0] == UBIS_IDX_DIVLO) begin
        divisor_q[7:0] <= w_data_q[7:0];
      end else if (wr_idx[3:0] == UBIS_IDX_DIVHI) begin
        divisor_q[15:8] <= w_data_q[7:0];
      end
    end
  end

  // Port strobes from writes: transmit byte and buffer clears
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_write_q    <= 1'b0;
      tx_data_q     <= UBIS_RST_BYTE;
      rx_fifo_clr_q <= 1'b0;
      tx_fifo_clr_q <= 1'b0;
    end else begin
      tx_write_q    <= wr_set0 && wr_idx[3:0] == UBIS_IDX_BUF;
      rx_fifo_clr_q <= wr_set0 && wr_idx[3:0] == UBIS_IDX_IRQST && w_data_q[UBIS_BCR_RXRST];
      tx_fifo_clr_q <= wr_set0 && wr_idx[3:0] == UBIS_IDX_IRQST && w_data_q[UBIS_BCR_TXRST];
      if (wr_set0 && wr_idx[3:0] == UBIS_IDX_BUF) begin
        tx_data_q <= w_data_q[7:0];
      end
    end
  end

  // Read data mux; sets 2 to 7 hold only the set select and configuration bits and read zero elsewhere
  logic [7:0] rd_byte;
  logic [4:0] rd_idx;
  logic [2:0] rd_set;
  assign rd_idx = reg_index(s_axi_araddr);
  assign rd_set = cur_set;

  always_comb begin
    rd_byte = 8'h00;
    if (rd_idx[3:0] == UBIS_IDX_CFG) begin
      rd_byte = {4'h0, cfg_q.bank_switch_enable, 1'b0, cfg_q.turbo_rate_select, cfg_q.fast_rate_select};
    end else if (rd_idx[3:0] == UBIS_IDX_LCR) begin
      rd_byte = cfg_q.bank_switch_enable ? {5'h00, set_q} : line_ctrl_q;
    end else if (rd_set == 3'h1) begin
      case (rd_idx[3:0])
        UBIS_IDX_DIVLO: rd_byte = divisor_q[7:0];
        UBIS_IDX_DIVHI: rd_byte = divisor_q[15:8];
        default:        rd_byte = 8'h00;
      endcase
    end else if (rd_set == 3'h0) begin
      case (rd_idx[3:0])
        UBIS_IDX_BUF:   rd_byte = rx_data;
        UBIS_IDX_IRQEN: rd_byte = {4'h0, irq_en_q};
        UBIS_IDX_IRQST: begin
          if (cfg_q.bank_switch_enable) begin
            rd_byte = {4'h0, pending};
          end else begin
            rd_byte = {{2{buffer_ctrl_q[UBIS_BCR_FIFO_EN]}}, 2'b00, encode_irq(pending)};
          end
        end
        UBIS_IDX_MCR:   rd_byte = modem_ctrl_q;
        UBIS_IDX_LSR:   rd_byte = line_status_in;
        UBIS_IDX_MSR:   rd_byte = modem_status_in;
        UBIS_IDX_SCR:   rd_byte = scratch_q;
        default:        rd_byte = 8'h00;
      endcase
    end
  end

  // Read channel: address taken when idle, data one cycle later held until taken
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_state_q <= UBIS_RD_IDLE;
      rdata_q    <= 32'h0000_0000;
      rresp_q    <= UBIS_RESP_OKAY;
    end else begin
      case (rd_state_q)
        UBIS_RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state_q <= UBIS_RD_RESP;
            rdata_q    <= {24'h000000, rd_byte};
            rresp_q    <= rd_idx[4] ? UBIS_RESP_SLVERR : UBIS_RESP_OKAY;
          end
        end
        UBIS_RD_RESP: begin
          if (s_axi_rready) begin
            rd_state_q <= UBIS_RD_IDLE;
          end
        end
        default: rd_state_q <= UBIS_RD_IDLE;
      endcase
    end
  end

  assign s_axi_arready = rd_state_q == UBIS_RD_IDLE;
  assign s_axi_rvalid  = rd_state_q == UBIS_RD_RESP;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Read side effects reach the port as one-cycle strobes so it can clear its flags
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_read_q         <= 1'b0;
      line_status_rd_q  <= 1'b0;
      modem_status_rd_q <= 1'b0;
      irq_ident_rd_q    <= 1'b0;
    end else begin
      rx_read_q         <= s_axi_arvalid && s_axi_arready && rd_set == 3'h0 && rd_idx == 5'(UBIS_IDX_BUF);
      line_status_rd_q  <= s_axi_arvalid && s_axi_arready && rd_set == 3'h0 && rd_idx == 5'(UBIS_IDX_LSR);
      modem_status_rd_q <= s_axi_arvalid && s_axi_arready && rd_set == 3'h0 && rd_idx == 5'(UBIS_IDX_MSR);
      irq_ident_rd_q    <= s_axi_arvalid && s_axi_arready && rd_set == 3'h0 && rd_idx == 5'(UBIS_IDX_IRQST);
    end
  end

  // Mode outputs for the buffers and flow control outside
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      advanced_mode_q <= 1'b0;
      set_select_q    <= UBIS_RST_SET;
    end else begin
      advanced_mode_q <= cfg_q.bank_switch_enable;
      set_select_q    <= cur_set;
    end
  end

  // Interrupt output: any enabled source, gated by the modem control output enable
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (|pending) && modem_ctrl_q[UBIS_MCR_IRQ_OE_BIT];
    end
  end

  // Fractional accumulator: turbo and normal tick at 24 MHz, fast at 14.746 MHz.
  // The ticks jitter by one core cycle; the 16x oversampling absorbs it.
  logic [16:0] acc_q;
  logic [16:0] acc_step;
  logic [17:0] acc_sum;
  logic        src_tick;
  assign acc_step = (cfg_q.fast_rate_select && !cfg_q.turbo_rate_select) ? ACC_FAST : ACC_SRC;
  assign acc_sum  = {1'b0, acc_q} + {1'b0, acc_step};
  assign src_tick = acc_sum >= {1'b0, ACC_MOD};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc_q <= 17'h00000;
    end else if (src_tick) begin
      acc_q <= 17'(acc_sum - {1'b0, ACC_MOD});
    end else begin
      acc_q <= acc_sum[16:0];
    end
  end

  // Prescaler by 13 makes the 1.8461 MHz tick; high speed modes bypass it
  logic [3:0] pre_q;
  logic       high_speed;
  logic       div_tick;
  assign high_speed = cfg_q.turbo_rate_select || cfg_q.fast_rate_select;
  assign div_tick   = src_tick && (high_speed || pre_q == PRE_TOP);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pre_q <= 4'h0;
    end else if (src_tick) begin
      pre_q <= (pre_q == PRE_TOP) ? 4'h0 : pre_q + 4'h1;
    end
  end

  // Divisor counter; a divisor write restarts the period so the new rate takes hold at once.
  // A zero divisor is outside the legal range and behaves as one.
  logic [15:0] div_cnt_q;
  logic        div_wr;
  assign div_wr = wr_set1 && (wr_idx[3:0] == UBIS_IDX_DIVLO || wr_idx[3:0] == UBIS_IDX_DIVHI);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_cnt_q <= 16'h0001;
      baud16_q  <= 1'b0;
    end else if (div_wr) begin
      div_cnt_q <= 16'h0001;
      baud16_q  <= 1'b0;
    end else if (div_tick) begin
      if (div_cnt_q >= divisor_q) begin
        div_cnt_q <= 16'h0001;
        baud16_q  <= 1'b1;
      end else begin
        div_cnt_q <= div_cnt_q + 16'h0001;
        baud16_q  <= 1'b0;
      end
    end else begin
      baud16_q <= 1'b0;
    end
  end

endmodule

// file: verification/ubis_uart_regs_chk.sv
module ubis_uart_regs_chk
  import ubis_pkg::*;
(
  // Clock and reset
  input wire logic          core_clk,
  input wire logic          rst,
  // Watched ports
  input wire ubis_irq_src_t irq_src,
  input wire logic [7:0]    modem_ctrl_q,
  input wire logic          irq_q,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready,
  input wire logic [31:0]   s_axi_rdata,
  input wire logic          baud16_q,
  input wire logic          rx_read_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // Interrupt needs the output enable and a live source one cycle earlier
  a_irq_oe_gate: assert property (!modem_ctrl_q[3] |=> !irq_q) else $error("irq while output disabled");
  a_irq_no_src: assert property (irq_src == 4'h0 |=> !irq_q) else $error("irq with no source");
  // Only bits 7:0 carry a register
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits");
  // Read answer timing and one read at a time
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read answer");
  a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read answer stuck");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  // Sampling tick is a single-cycle pulse; the source tick is slower than core_clk
  a_baud_single: assert property (baud16_q |=> !baud16_q) else $error("wide baud pulse");
  a_rx_strobe: assert property (rx_read_q |-> $rose(s_axi_rvalid)) else $error("stray rx strobe");

  c_irq: cover property (irq_q);
  c_baud: cover property (baud16_q);
  c_rx_rd: cover property (rx_read_q);
endmodule

bind ubis_uart_regs ubis_uart_regs_chk u_chk (.core_clk(core_clk), .rst(rst), .irq_src(irq_src),
  .modem_ctrl_q(modem_ctrl_q), .irq_q(irq_q), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .baud16_q(baud16_q),
  .rx_read_q(rx_read_q));

// file: verification/ubis_port_model.sv
module ubis_port_model
  import ubis_pkg::*;
(
  // Clock and reset
  input wire logic     core_clk,
  input wire logic     rst,
  // Events raised by the bench
  input wire logic [3:0] raise,
  // Read strobes from the block
  input wire logic     rx_rd,
  input wire logic     tx_ack,
  input wire logic     line_rd,
  input wire logic     modem_rd,
  // Toward the block
  output ubis_irq_src_t irq_src,
  output logic [7:0]   rx_data,
  output logic [7:0]   line_status_in,
  output logic [7:0]   modem_status_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] pend_q;

  // Flags stay set until the read that clears them, so a late read keeps irq up
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend_q <= 4'h0;
    end else begin
      pend_q <= (pend_q | raise) & ~{modem_rd, line_rd, tx_ack, rx_rd};
    end
  end

  // Fixed status bytes
  assign irq_src         = pend_q;
  assign rx_data         = 8'h5a;
  assign line_status_in  = 8'h60;
  assign modem_status_in = 8'hb0;
endmodule

// file: verification/ubis_uart_regs_test.sv
module ubis_uart_regs_test
  import ubis_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          core_clk = 0;
  logic          rst = 1;
  logic [5:0]    awa, ara;
  logic [31:0]   wd;
  logic          awv, wv, arv;
  logic [3:0]    raise;
  logic [7:0]    d;
  wire           awr, wrdy, bv, arr, rv, irq, b16, adv, rx_rd, ls_rd, ms_rd, id_rd, txw, rxc, txc;
  wire [31:0]    rdat;
  wire [1:0]     rr, br;
  wire [2:0]     sel;
  wire [7:0]     rxd, lsi, msi, txd, lcr, mcr, bcr;
  logic [1:0]    bexp;
  ubis_irq_src_t src;
  logic [33:0]   exp_q[$];
  int            bad_count, n_checks, cyc;
  // Per enable bit: identifier and the read that clears its source
  localparam logic [3:0] ID[4] = '{UBIS_ID_RX, UBIS_ID_TX, UBIS_ID_LINE, UBIS_ID_MODEM};
  localparam logic [3:0] CLR[4] = '{4'h0, 4'h2, 4'h5, 4'h6};
  localparam logic [7:0] CLRV[4] = '{8'h5a, 8'h01, 8'h60, 8'hb0};

  ubis_uart_regs i_dut (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
    .irq_src(src), .rx_data(rxd), .line_status_in(lsi), .modem_status_in(msi), .rx_read_q(rx_rd),
    .tx_write_q(txw), .tx_data_q(txd), .line_status_rd_q(ls_rd), .modem_status_rd_q(ms_rd), .irq_ident_rd_q(id_rd),
    .rx_fifo_clr_q(rxc), .tx_fifo_clr_q(txc), .line_ctrl_q(lcr), .modem_ctrl_q(mcr), .buffer_ctrl_q(bcr),
    .advanced_mode_q(adv), .set_select_q(sel), .baud16_q(b16), .irq_q(irq));
  ubis_port_model i_port (.core_clk(core_clk), .rst(rst), .raise(raise), .rx_rd(rx_rd), .tx_ack(id_rd),
    .line_rd(ls_rd), .modem_rd(ms_rd), .irq_src(src), .rx_data(rxd), .line_status_in(lsi),
    .modem_status_in(msi));

  always #4 core_clk = ~core_clk;

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Address and data offered together, each released when taken
  task automatic wr(input logic [3:0] i, input logic [7:0] v);
    bit a = 1;
    bit w = 1;
    awa <= {i, 2'b00};
    wd <= {24'h0, v};
    awv <= 1;
    wv <= 1;
    while (a || w) begin
      @(posedge core_clk);
      if (a && awr) begin
        a = 0;
        awv <= 0;
      end
      if (w && wrdy) begin
        w = 0;
        wv <= 0;
      end
    end
    do @(posedge core_clk); while (!bv);
  endtask

  // Expectation is queued; the monitor compares when the answer shows
  task automatic rd(input logic [3:0] i, input logic [33:0] e);
    exp_q.push_back(e);
    ara <= {i, 2'b00};
    arv <= 1;
    do @(posedge core_clk); while (!arr);
    arv <= 0;
    do @(posedge core_clk); while (!rv);
  endtask

  // Program rate through set 1, then time four sampling periods
  task automatic baud(input logic [15:0] dv, input logic [7:0] cf, input int lo, input int hi);
    int n = 0;
    wr(4'h8, cf);
    wr(4'h3, 8'h80);
    chk(34'(lcr), 34'h80);
    wr(4'h0, dv[7:0]);
    wr(4'h1, dv[15:8]);
    wr(4'h3, 8'h00);
    do @(posedge core_clk); while (!b16);
    repeat (4) do begin
      @(posedge core_clk);
      n++;
    end while (!b16);
    chk(34'(n >= lo && n <= hi), 34'h1);
  endtask

  always @(posedge core_clk) begin
    if (!rst && rv !== 1'b0) chk({rr, rdat}, exp_q.pop_front());
    if (!rst && bv !== 1'b0) chk(34'(br), 34'(bexp));
  end

  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      test_done;
    end
  end

  initial begin
    awa = 0; ara = 0; wd = 0; awv = 0; wv = 0; arv = 0; raise = 0; bexp = UBIS_RESP_OKAY;
    void'($urandom(24509));
    repeat (16) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk);
    rd(4'h1, 34'h0);
    rd(4'h9, {UBIS_RESP_SLVERR, 32'h0});
    // Unmapped write must answer an error; restored by NBA so the monitor sees it
    bexp <= UBIS_RESP_SLVERR;
    wr(4'h9, 8'hff);
    bexp <= UBIS_RESP_OKAY;
    wr(4'h4, 8'h08);
    chk(34'(mcr), 34'h08);
    for (int i = 0; i < 4; i++) begin
      raise <= 4'(1 << i);
      wr(4'h1, 8'hf0 | 8'(1 << i));
      raise <= 4'h0;
      repeat (2) @(posedge core_clk);
      chk(34'(irq), 34'h1);
      rd(4'h1, 34'(8'(1 << i)));
      rd(4'h2, 34'(ID[i]));
      wr(4'h1, 8'h0f ^ 8'(1 << i));
      repeat (2) @(posedge core_clk);
      chk(34'(irq), 34'h0);
      rd(CLR[i], 34'(CLRV[i]));
    end
    raise <= 4'hf;
    wr(4'h1, 8'h00);
    raise <= 4'h0;
    repeat (2) @(posedge core_clk);
    chk(34'(irq), 34'h0);
    // Buffer clears pulse once and fall back; buffer enable shows in the status byte
    wr(4'h2, 8'h07);
    chk(34'({rxc, txc, bcr}), 34'h307);
    rd(4'h2, 34'hc1);
    chk(34'(bcr), 34'h01);
    for (int k = 0; k < 4; k++) begin
      d = 8'($urandom);
      wr(4'h7, d);
      rd(4'h7, {26'h0, d});
    end
    wr(4'h0, 8'ha5);
    chk(34'({txw, txd}), 34'h1a5);
    baud(16'h0001, 8'h00, 270, 272);
    baud(16'h000c, 8'h00, 3249, 3251);
    baud(16'h0001, 8'h02, 20, 22);
    baud(16'h0004, 8'h01, 135, 137);
    baud(16'h0001, 8'h01, 33, 35);
    wr(4'h8, 8'h08);
    wr(4'h3, 8'h81);
    @(posedge core_clk);
    chk(34'(adv), 34'h1);
    chk(34'(sel), 34'h1);
    rd(4'h3, 34'h1);
    wr(4'h3, 8'h87);
    rd(4'h7, 34'h0);
    wr(4'h3, 8'h00);
    rd(4'h7, {26'h0, d});
    // Advanced status is one plain bit per enabled source
    wr(4'h1, 8'h05);
    rd(4'h2, 34'h05);
    test_done;
  end
endmodule
